// ==== core/psi_consts.svh ====
`ifndef PSI_CONSTS_SVH
`define PSI_CONSTS_SVH
// instruction encoding
`define PSI_OP_SYSTEM   7'h73
`define PSI_F3_TRAP     3'h0
`define PSI_F12_ENVIRONMENT_CALL_INSTR   12'h000
`define PSI_F12_BREAKPOINT_INSTR  12'h001
`define PSI_F12_SUPERVISOR_TRAP_RETURN    12'h102
`define PSI_F12_MACHINE_TRAP_RETURN    12'h302
`define PSI_F12_WFI     12'h105
`define PSI_COMPRESSED_BREAKPOINT_INSTR    16'h9002
// privilege codes
`define PSI_TRAP_MINOR_OPCODE_U      2'h0
`define PSI_TRAP_MINOR_OPCODE_S      2'h1
`define PSI_TRAP_MINOR_OPCODE_M      2'h3
// exception causes; environment call cause is {base, privilege}
`define PSI_ENVIRONMENT_CALL_INSTR_BASE  2'h2
`define PSI_CAUSE_BRK   4'h3
`define PSI_CAUSE_ILL   4'h2
`define PSI_PC_STEP     32'h4
// register map (byte addresses)
`define PSI_ADDR_CTRL   4'h0
`define PSI_ADDR_STAT   4'h4
// control register bits
`define PSI_CTRL_TSR    0
`define PSI_CTRL_TW     1
`define PSI_CTRL_SMODE  2
`define PSI_CTRL_UWFI   3
`define PSI_CTRL_NOP    4
`define PSI_CTRL_CLRRES 5
`define PSI_CTRL_W      6
`define PSI_CTRL_RST    6'h04
// bus responses
`define PSI_RESP_OK     2'h0
`define PSI_RESP_ERR    2'h2
`endif

// ==== core/psi_pkg.sv ====
package psi_pkg;
  typedef enum logic [1:0] {
    PSI_IDLE = 2'b01,
    PSI_WAIT = 2'b10
  } psi_state_t;

  typedef enum logic [5:0] {
    PSI_K_NONE  = 6'h01,
    PSI_K_ENVIRONMENT_CALL_INSTR = 6'h02,
    PSI_K_EBRK  = 6'h04,
    PSI_K_MACHINE_TRAP_RETURN  = 6'h08,
    PSI_K_SUPERVISOR_TRAP_RETURN  = 6'h10,
    PSI_K_WFI   = 6'h20
  } psi_kind_t;

  typedef struct packed {
    logic       mie;
    logic       mpie;
    logic [1:0] mpp;
    logic       supervisor_global_irq_enable;
    logic       spie;
    logic       spp;
  } psi_stack_t;

  typedef struct packed {
    logic        exc;
    logic [3:0]  cause;
    logic [31:0] epc;
    logic        jump;
    logic [31:0] pc;
    logic        stack_we;
    logic [1:0]  trap_minor_opcode;
    psi_stack_t  st;
    logic        retire;
    logic        clr_resv;
    logic        wake_irq;
  } psi_res_t;
endpackage

// ==== core/psi_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psi_consts.svh"
module psi_decode
  import psi_pkg::*;
(
  input  wire logic [31:0] instr,
  input  wire logic        compressed,
  output psi_kind_t        kind
);
  logic       trap_form;
  logic [11:0] f12;

  // fixed fields of the trap minor opcode: source and destination zero
  assign f12       = instr[31:20];
  assign trap_form = instr[6:0] == `PSI_OP_SYSTEM && instr[14:12] == `PSI_F3_TRAP &&
                     instr[19:15] == 5'h00 && instr[11:7] == 5'h00;

  // function code selects the operation
  always_comb begin
    kind = PSI_K_NONE;
    if (compressed) begin
      if (instr[15:0] == `PSI_COMPRESSED_BREAKPOINT_INSTR) kind = PSI_K_EBRK;
    end else if (trap_form) begin
      unique case (f12)
        `PSI_F12_ENVIRONMENT_CALL_INSTR:  kind = PSI_K_ENVIRONMENT_CALL_INSTR;
        `PSI_F12_BREAKPOINT_INSTR: kind = PSI_K_EBRK;
        `PSI_F12_MACHINE_TRAP_RETURN:   kind = PSI_K_MACHINE_TRAP_RETURN;
        `PSI_F12_SUPERVISOR_TRAP_RETURN:   kind = PSI_K_SUPERVISOR_TRAP_RETURN;
        `PSI_F12_WFI:    kind = PSI_K_WFI;
        default:         kind = PSI_K_NONE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== core/psi_stack_pop.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psi_consts.svh"
module psi_stack_pop
  import psi_pkg::*;
(
  input  wire psi_stack_t  st_in,
  input  wire logic        from_m,
  output psi_stack_t       st_out,
  output logic [1:0]       trap_minor_opcode
);
  // pop only the stack of the level being returned from
  always_comb begin
    st_out = st_in;
    if (from_m) begin
      trap_minor_opcode        = st_in.mpp;
      st_out.mie  = st_in.mpie;
      st_out.mpie = 1'b1;
      st_out.mpp  = `PSI_TRAP_MINOR_OPCODE_U; // lowest mode left behind
    end else begin
      trap_minor_opcode        = {1'b0, st_in.spp};
      st_out.supervisor_global_irq_enable  = st_in.spie;
      st_out.spie = 1'b1;
      st_out.spp  = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== core/psi_sys_unit.sv ====
// How it works
// - environment call traps, cause names origin mode
// - breakpoint raises breakpoint exception only
// - trap pc is the instruction itself
// - calls and breakpoints never count as retired
// - decode fixed trap-form fields, zero registers
// - machine return always; supervisor only if present
// - supervisor return illegal in supervisor mode when trap bit set
// - return at own level or higher pops stack
// - return jumps to saved pc of level
// - return may drop reservation, software selectable
// - wait instruction stalls in privileged modes, user optional
// - wait illegal outside machine mode when timeout-wait bit set
// - wake by interrupt resumes at pc plus four
// - wait may end early, no-op mode allowed
// - wake ignores global enables and delegation
// - wake needs the individual enable bit
// - wake without interrupt continues at pc plus four
// - wait may trap to higher mode immediately
// - compressed breakpoint acts as full breakpoint
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "psi_consts.svh"
module psi_sys_unit
  import psi_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [3:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [3:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        issue_valid,
  output logic             issue_ready,
  input  wire logic [31:0] issue_instr,
  input  wire logic [31:0] issue_pc,
  input  wire logic        issue_compressed,
  input  wire logic [1:0]  cur_trap_minor_opcode,
  input  wire psi_stack_t  stack_in,
  input  wire logic [31:0] mepc,
  input  wire logic [31:0] sepc,
  input  wire logic [15:0] irq_pending,
  input  wire logic [15:0] irq_enable,
  output logic             res_valid,
  output psi_res_t         res,
  output logic             wfi_sleep
);
  psi_state_t              state;
  psi_state_t              next_state;
  psi_kind_t               kind;
  psi_res_t                next_res;
  logic                    next_res_valid;
  psi_stack_t              pop_st;
  logic [1:0]              pop_trap_minor_opcode;
  logic                    take;
  logic                    wake;
  logic [31:0]             pc_q;
  logic [`PSI_CTRL_W-1:0]  ctrl;
  logic [3:0]              last_cause;
  logic                    last_exc;
  logic [7:0]              ill_cnt;
  logic                    aw_held;
  logic                    w_held;
  logic [3:0]              aw_addr_q;
  logic [31:0]             w_data_q;
  logic                    w_strb0_q;
  logic                    wr_fire;
  logic                    ill_evt;

  psi_decode u_decode (
    .instr      (issue_instr),
    .compressed (issue_compressed),
    .kind       (kind)
  );

  psi_stack_pop u_pop (
    .st_in  (stack_in),
    .from_m (kind == PSI_K_MACHINE_TRAP_RETURN),
    .st_out (pop_st),
    .trap_minor_opcode   (pop_trap_minor_opcode)
  );

  // handshake toward decode; stalled while sleeping
  assign issue_ready = state == PSI_IDLE;
  assign take        = issue_valid && issue_ready;
  assign wfi_sleep   = state == PSI_WAIT;

  // only individually enabled lines wake; global enables never looked at
  assign wake = |(irq_pending & irq_enable);

  // operation result and wait sequencing
  always_comb begin
    next_res       = '0;
    next_res_valid = 1'b0;
    next_state     = state;
    next_res.st    = stack_in;
    next_res.trap_minor_opcode  = cur_trap_minor_opcode;
    if (state == PSI_WAIT) begin
      next_res.epc = pc_q;
      if (wake) begin
        next_res_valid    = 1'b1;
        next_res.jump     = 1'b1;
        next_res.pc       = pc_q + `PSI_PC_STEP;
        next_res.retire   = 1'b1;
        next_res.wake_irq = 1'b1; // trap control takes the interrupt here
        next_state        = PSI_IDLE;
      end
    end else if (issue_valid) begin
      next_res_valid = 1'b1;
      next_res.epc   = issue_pc;
      unique case (kind)
        PSI_K_ENVIRONMENT_CALL_INSTR: begin
          next_res.exc   = 1'b1;
          next_res.cause = {`PSI_ENVIRONMENT_CALL_INSTR_BASE, cur_trap_minor_opcode};
        end
        PSI_K_EBRK: begin
          next_res.exc   = 1'b1;
          next_res.cause = `PSI_CAUSE_BRK;
        end
        PSI_K_MACHINE_TRAP_RETURN: begin
          if (cur_trap_minor_opcode == `PSI_TRAP_MINOR_OPCODE_M) begin
            next_res.jump     = 1'b1;
            next_res.pc       = mepc;
            next_res.stack_we = 1'b1;
            next_res.trap_minor_opcode     = pop_trap_minor_opcode;
            next_res.st       = pop_st;
            next_res.retire   = 1'b1;
            next_res.clr_resv = ctrl[`PSI_CTRL_CLRRES];
          end else begin
            next_res.exc   = 1'b1;
            next_res.cause = `PSI_CAUSE_ILL;
          end
        end
        PSI_K_SUPERVISOR_TRAP_RETURN: begin
          if (!ctrl[`PSI_CTRL_SMODE] || cur_trap_minor_opcode == `PSI_TRAP_MINOR_OPCODE_U ||
              (ctrl[`PSI_CTRL_TSR] && cur_trap_minor_opcode == `PSI_TRAP_MINOR_OPCODE_S)) begin
            next_res.exc   = 1'b1;
            next_res.cause = `PSI_CAUSE_ILL;
          end else begin
            next_res.jump     = 1'b1;
            next_res.pc       = sepc;
            next_res.stack_we = 1'b1;
            next_res.trap_minor_opcode     = pop_trap_minor_opcode;
            next_res.st       = pop_st;
            next_res.retire   = 1'b1;
            next_res.clr_resv = ctrl[`PSI_CTRL_CLRRES];
          end
        end
        PSI_K_WFI: begin
          if ((cur_trap_minor_opcode == `PSI_TRAP_MINOR_OPCODE_U && !ctrl[`PSI_CTRL_UWFI]) ||
              (ctrl[`PSI_CTRL_TW] && cur_trap_minor_opcode != `PSI_TRAP_MINOR_OPCODE_M)) begin
            next_res.exc   = 1'b1;
            next_res.cause = `PSI_CAUSE_ILL;
          end else if (ctrl[`PSI_CTRL_NOP] || wake) begin
            // nothing to wait for, finish in one step
            next_res.jump     = 1'b1;
            next_res.pc       = issue_pc + `PSI_PC_STEP;
            next_res.retire   = 1'b1;
            next_res.wake_irq = wake;
          end else begin
            next_res_valid = 1'b0;
            next_state     = PSI_WAIT;
          end
        end
        PSI_K_NONE: begin
          next_res.exc   = 1'b1; // unknown system encodings
          next_res.cause = `PSI_CAUSE_ILL;
        end
      endcase
    end
  end

  assign ill_evt = next_res_valid && next_res.exc && next_res.cause == `PSI_CAUSE_ILL;

  // sleep state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= PSI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // pc of the instruction under way, kept for the wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= 32'h0;
    end else if (take) begin
      pc_q <= issue_pc;
    end
  end

  // registered result, pulse per finished instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_valid <= 1'b0;
      res       <= '0;
    end else begin
      res_valid <= next_res_valid;
      res       <= next_res;
    end
  end

  // status history seen by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_cause <= 4'h0;
      last_exc   <= 1'b0;
      ill_cnt    <= 8'h00;
    end else begin
      if (next_res_valid) begin
        last_exc   <= next_res.exc;
        last_cause <= next_res.cause;
      end
      if (ill_evt) ill_cnt <= ill_cnt + 8'h01; // wraps, a hint not a log
    end
  end

  // write channel: address and data taken in either order
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign wr_fire = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q  <= 32'h0;
      w_strb0_q <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `PSI_RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held    <= 1'b1;
        w_data_q  <= wdata;
        w_strb0_q <= wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (aw_addr_q == `PSI_ADDR_CTRL || aw_addr_q == `PSI_ADDR_STAT) ?
                   `PSI_RESP_OK : `PSI_RESP_ERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // control register; only the low byte lane holds bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `PSI_CTRL_RST;
    end else if (wr_fire && aw_addr_q == `PSI_ADDR_CTRL && w_strb0_q) begin
      ctrl <= w_data_q[`PSI_CTRL_W-1:0];
    end
  end

  // read channel, one word outstanding
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= `PSI_RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= `PSI_RESP_OK;
      unique case (araddr)
        `PSI_ADDR_CTRL: rdata <= {{(32-`PSI_CTRL_W){1'b0}}, ctrl};
        `PSI_ADDR_STAT: rdata <= {16'h0, ill_cnt, 2'h0, last_exc, last_cause, wfi_sleep};
        default: begin
          rdata <= 32'h0;
          rresp <= `PSI_RESP_ERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // checks on the finished-instruction stream
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_environment_call_instr_cause: assert property (take && kind == PSI_K_ENVIRONMENT_CALL_INSTR |=>
    res_valid && res.exc && res.cause == {`PSI_ENVIRONMENT_CALL_INSTR_BASE, $past(cur_trap_minor_opcode)})
    else $error("environment call cause wrong");

  a_brk_cause: assert property (take && kind == PSI_K_EBRK |=>
    res_valid && res.exc && res.cause == `PSI_CAUSE_BRK && !res.jump)
    else $error("breakpoint result wrong");

  a_exc_epc_self: assert property (take |=> !res.exc || res.epc == $past(issue_pc))
    else $error("exception pc is not the instruction pc");

  a_exc_no_retire: assert property (res_valid && res.exc |-> !res.retire && !res.stack_we)
    else $error("exception counted as retired");

  a_machine_trap_return_target: assert property (take && kind == PSI_K_MACHINE_TRAP_RETURN && cur_trap_minor_opcode == `PSI_TRAP_MINOR_OPCODE_M |=>
    res.jump && res.stack_we && res.pc == $past(mepc))
    else $error("machine return target wrong");

  a_ret_low_trap_minor_opcode: assert property (take && kind == PSI_K_MACHINE_TRAP_RETURN && cur_trap_minor_opcode != `PSI_TRAP_MINOR_OPCODE_M |=>
    res.exc && res.cause == `PSI_CAUSE_ILL && !res.jump && !res.stack_we)
    else $error("return above current mode not refused");

  a_supervisor_trap_return_trap_bit: assert property (take && kind == PSI_K_SUPERVISOR_TRAP_RETURN && ctrl[`PSI_CTRL_TSR] &&
    cur_trap_minor_opcode == `PSI_TRAP_MINOR_OPCODE_S |=> res.exc && !res.stack_we)
    else $error("supervisor return not refused");

  a_wfi_tw_trap: assert property (take && kind == PSI_K_WFI && ctrl[`PSI_CTRL_TW] &&
    cur_trap_minor_opcode != `PSI_TRAP_MINOR_OPCODE_M |=> res_valid && res.exc && state == PSI_IDLE)
    else $error("wait not refused with timeout-wait set");

  a_wfi_wake_pc: assert property (state == PSI_WAIT && wake |=>
    res_valid && res.wake_irq && res.pc == $past(pc_q) + `PSI_PC_STEP && state == PSI_IDLE)
    else $error("wake did not resume at next instruction");

  a_wfi_no_wake: assert property (state == PSI_WAIT && !wake |=> !res_valid && !issue_ready)
    else $error("left wait without enabled interrupt");

  c_wfi_sleep_wake: cover property (take && kind == PSI_K_WFI ##1 state == PSI_WAIT ##[1:20] res_valid);
  c_machine_trap_return_done: cover property (res_valid && res.jump && res.stack_we);
  c_environment_call_instr_user: cover property (take && kind == PSI_K_ENVIRONMENT_CALL_INSTR && cur_trap_minor_opcode == `PSI_TRAP_MINOR_OPCODE_U);
endmodule
`default_nettype wire

// ==== sim/psi_hart_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module psi_hart_model
  import psi_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       res_valid,
  input  var psi_res_t    res,
  input  wire logic       ld,
  input  wire logic [1:0] ld_trap_minor_opcode,
  input  var psi_stack_t  ld_stack,
  output logic [1:0]      cur_trap_minor_opcode,
  output psi_stack_t      stack
);
  // trap control: holds mode and status stack, applies what the unit hands back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_trap_minor_opcode <= 2'h3;  // hart leaves reset in machine mode
      stack    <= '0;
    end else if (ld) begin
      cur_trap_minor_opcode <= ld_trap_minor_opcode;  // bench preset, beats a result in the same cycle
      stack    <= ld_stack;
    end else if (res_valid && res.stack_we) begin
      cur_trap_minor_opcode <= res.trap_minor_opcode;
      stack    <= res.st;
    end
  end
endmodule
`default_nettype wire

// ==== sim/psi_sys_unit_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psi_consts.svh"
module psi_sys_unit_tb
  import psi_pkg::*;
;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ld, slept;
  logic        issue_valid, issue_ready, issue_compressed, res_valid, wfi_sleep;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, issue_instr, issue_pc, mepc, sepc;
  logic [1:0]  bresp, rresp, cur_trap_minor_opcode, ld_trap_minor_opcode;
  logic [15:0] irq_pending, irq_enable;
  psi_stack_t  stack, ld_stack;
  psi_res_t    res, got;
  int          n_mismatch, checks_done, cyc, ans_t, k;
  logic [1:0]  pv [3] = '{2'h0, 2'h1, 2'h3};

  psi_sys_unit dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .issue_valid(issue_valid), .issue_ready(issue_ready),
    .issue_instr(issue_instr), .issue_pc(issue_pc), .issue_compressed(issue_compressed),
    .cur_trap_minor_opcode(cur_trap_minor_opcode), .stack_in(stack), .mepc(mepc), .sepc(sepc), .irq_pending(irq_pending),
    .irq_enable(irq_enable), .res_valid(res_valid), .res(res), .wfi_sleep(wfi_sleep));
  psi_hart_model hart (.aclk(aclk), .aresetn(aresetn), .res_valid(res_valid), .res(res), .ld(ld),
    .ld_trap_minor_opcode(ld_trap_minor_opcode), .ld_stack(ld_stack), .cur_trap_minor_opcode(cur_trap_minor_opcode), .stack(stack));

  // free-running clock, 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far above the length of the whole sequence
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // handshakes judged mid-cycle, where they equal what the next edge samples
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    hb = 1'b0;
    for (int t = 0; t < 40 && !hb; t++) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({hb, 29'h0, r}, {1'b1, 29'h0, er});
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    hr = 1'b0;
    for (int t = 0; t < 40 && !hr; t++) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(d, ed);
    chk({hr, 29'h0, r}, {1'b1, 29'h0, er});
  endtask

  task automatic set_hart(input logic [1:0] p, input logic [6:0] s);
    @(posedge aclk);
    ld_trap_minor_opcode  <= p;
    ld_stack <= psi_stack_t'(s);
    ld       <= 1'b1;
    @(posedge aclk);
    ld <= 1'b0;
  endtask

  // issue one instruction; an enabled line rises after wake_n+1 sleeping cycles
  task automatic run(input logic [31:0] i, input logic [31:0] p, input logic c, input int wake_n);
    logic tk, dn;
    @(posedge aclk);
    issue_instr      <= i;
    issue_pc         <= p;
    issue_compressed <= c;
    issue_valid      <= 1'b1;
    tk = 1'b0;
    dn = 1'b0;
    slept = 1'b0;
    for (int t = 0; t < 20 && !tk; t++) begin
      @(negedge aclk);
      tk = issue_ready;
      @(posedge aclk);
    end
    issue_valid <= 1'b0;
    for (ans_t = 0; ans_t < 60 && !dn; ans_t++) begin
      @(negedge aclk);
      dn = res_valid;
      got = res;
      slept = slept | wfi_sleep;
      @(posedge aclk);
      if (ans_t == wake_n) irq_pending <= irq_pending | 16'h0080;
    end
    chk({31'h0, dn}, 32'h1);
  endtask

  function automatic logic [31:0] sys(input logic [11:0] f, input logic [4:0] rs);
    return {f, rs, `PSI_F3_TRAP, 5'h0, `PSI_OP_SYSTEM};
  endfunction

  // exception result: no jump, no stack write, not retired
  task automatic exp_exc(input logic [3:0] ca, input logic [31:0] p);
    chk({24'h0, got.exc, got.cause, got.jump, got.stack_we, got.retire}, {24'h0, 1'b1, ca, 3'h0});
    chk(got.epc, p);
  endtask

  task automatic exp_jmp(input logic [31:0] p);
    chk({30'h0, got.exc, got.jump}, 32'h1);
    chk(got.pc, p);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ld, issue_valid, issue_compressed} = '0;
    {awaddr, araddr, wstrb, wdata, issue_instr, issue_pc, ld_trap_minor_opcode} = '0;
    ld_stack    = '0;
    irq_pending = 16'h0;
    irq_enable  = 16'h0080;
    mepc        = 32'h0000_1A00;
    sepc        = 32'h0000_2B00;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`PSI_ADDR_CTRL, 32'h4, `PSI_RESP_OK);
    axi_rd(4'h8, 32'h0, `PSI_RESP_ERR);
    axi_wr(4'hC, 32'hF, `PSI_RESP_ERR);
    // calls from every mode, then both breakpoint forms
    for (k = 0; k < 3; k++) begin
      set_hart(pv[k], 7'h0);
      run(sys(`PSI_F12_ENVIRONMENT_CALL_INSTR, 5'h0), 32'h100 + 4 * k, 1'b0, 99);
      exp_exc({`PSI_ENVIRONMENT_CALL_INSTR_BASE, pv[k]}, 32'h100 + 4 * k);
    end
    run(sys(`PSI_F12_BREAKPOINT_INSTR, 5'h0), 32'h200, 1'b0, 99);
    exp_exc(`PSI_CAUSE_BRK, 32'h200);
    run({16'h0, `PSI_COMPRESSED_BREAKPOINT_INSTR}, 32'h206, 1'b1, 99);
    exp_exc(`PSI_CAUSE_BRK, 32'h206);
    // machine return into S, then supervisor return right behind it
    set_hart(`PSI_TRAP_MINOR_OPCODE_M, 7'h2B);
    run(sys(`PSI_F12_MACHINE_TRAP_RETURN, 5'h0), 32'h300, 1'b0, 99);
    exp_jmp(mepc);
    chk({26'h0, got.stack_we, got.trap_minor_opcode, got.st.mie, got.st.mpp}, {26'h0, 1'b1, 2'h1, 1'b1, 2'h0});
    run(sys(`PSI_F12_SUPERVISOR_TRAP_RETURN, 5'h0), 32'h304, 1'b0, 99);
    exp_jmp(sepc);
    chk({29'h0, got.trap_minor_opcode, got.st.supervisor_global_irq_enable}, {29'h0, 2'h1, 1'b1});
    run(sys(`PSI_F12_MACHINE_TRAP_RETURN, 5'h0), 32'h308, 1'b0, 99);
    exp_exc(`PSI_CAUSE_ILL, 32'h308);
    set_hart(`PSI_TRAP_MINOR_OPCODE_M, 7'h2A);
    run(sys(`PSI_F12_SUPERVISOR_TRAP_RETURN, 5'h0), 32'h30C, 1'b0, 99);
    exp_jmp(sepc);
    chk({30'h0, got.trap_minor_opcode}, 32'h0);
    // machine mode, so only the nonzero source field can make it illegal
    set_hart(`PSI_TRAP_MINOR_OPCODE_M, 7'h2B);
    run(sys(`PSI_F12_MACHINE_TRAP_RETURN, 5'h1), 32'h310, 1'b0, 99);
    exp_exc(`PSI_CAUSE_ILL, 32'h310);
    axi_wr(`PSI_ADDR_CTRL, 32'h5, `PSI_RESP_OK);
    set_hart(`PSI_TRAP_MINOR_OPCODE_S, 7'h2B);
    run(sys(`PSI_F12_SUPERVISOR_TRAP_RETURN, 5'h0), 32'h314, 1'b0, 99);
    exp_exc(`PSI_CAUSE_ILL, 32'h314);
    axi_wr(`PSI_ADDR_CTRL, 32'h0, `PSI_RESP_OK);
    set_hart(`PSI_TRAP_MINOR_OPCODE_M, 7'h2B);
    run(sys(`PSI_F12_SUPERVISOR_TRAP_RETURN, 5'h0), 32'h318, 1'b0, 99);
    exp_exc(`PSI_CAUSE_ILL, 32'h318);
    // sleep with globals off and a pending line that is not enabled
    axi_wr(`PSI_ADDR_CTRL, 32'h4, `PSI_RESP_OK);
    set_hart(`PSI_TRAP_MINOR_OPCODE_M, 7'h0);
    irq_pending <= 16'h0008;
    run(sys(`PSI_F12_WFI, 5'h0), 32'h400, 1'b0, 4);
    chk(ans_t, 32'h7);
    chk({31'h0, slept}, 32'h1);
    exp_jmp(32'h404);
    chk({29'h0, got.wake_irq, got.retire, got.exc}, 32'h6);
    run(sys(`PSI_F12_WFI, 5'h0), 32'h408, 1'b0, 99);
    exp_jmp(32'h40C);
    chk({30'h0, ans_t == 1, got.wake_irq}, 32'h3);
    irq_pending <= 16'h0;
    axi_wr(`PSI_ADDR_CTRL, 32'h6, `PSI_RESP_OK);
    set_hart(`PSI_TRAP_MINOR_OPCODE_S, 7'h0);
    run(sys(`PSI_F12_WFI, 5'h0), 32'h410, 1'b0, 99);
    exp_exc(`PSI_CAUSE_ILL, 32'h410);
    axi_wr(`PSI_ADDR_CTRL, 32'h4, `PSI_RESP_OK);
    set_hart(`PSI_TRAP_MINOR_OPCODE_U, 7'h0);
    run(sys(`PSI_F12_WFI, 5'h0), 32'h414, 1'b0, 99);
    exp_exc(`PSI_CAUSE_ILL, 32'h414);
    // user mode may wait here, and the wait is a no-op
    axi_wr(`PSI_ADDR_CTRL, 32'h1C, `PSI_RESP_OK);
    run(sys(`PSI_F12_WFI, 5'h0), 32'h418, 1'b0, 99);
    exp_jmp(32'h41C);
    chk({31'h0, got.wake_irq}, 32'h0);
    axi_wr(`PSI_ADDR_CTRL, 32'h24, `PSI_RESP_OK);
    set_hart(`PSI_TRAP_MINOR_OPCODE_M, 7'h2B);
    run(sys(`PSI_F12_MACHINE_TRAP_RETURN, 5'h0), 32'h500, 1'b0, 99);
    chk({31'h0, got.clr_resv}, 32'h1);
    axi_wr(`PSI_ADDR_STAT, 32'hFFFF_FFFF, `PSI_RESP_OK);
    axi_rd(`PSI_ADDR_CTRL, 32'h24, `PSI_RESP_OK);
    // six refused instructions counted, last result a clean return, not asleep
    axi_rd(`PSI_ADDR_STAT, 32'h0000_0600, `PSI_RESP_OK);
    tally_and_finish();
  end
endmodule
`default_nettype wire
